// File: fan_pwm_opt_pkg.sv
// Constants, register map and state codes for the fan PWM and tach option block
// What this block does
// - Lock bit freezes the three option registers
// - Update field: 1 s, 0.5 s, 300 ms
// - Zero duty: snap off, or ramp down
// - Guard after PWM rise: 63/32/16/8 oscillator clocks
// - Opportunistic mode refreshes on every valid reading
// - Opportunistic valid reading restarts update counter
// - Glitch bit: deglitch tach after synchronising
// - Sync bit clear: leave spin-up at once
// - Sync bit set: leave spin-up at period start
// - Rollover bit: mode 1 rolls at 0080h/FFFFh
// - Scale bit set: 256-count full-resolution duty
// - Mode 2 measures only while PWM high
package fan_pwm_opt_pkg;
  // Register addresses
  localparam logic [7:0] OPT_CH1_ADDR = 8'h94; // Channel 1 options
  localparam logic [7:0] OPT_CH2_ADDR = 8'h95; // Channel 2 options
  localparam logic [7:0] OPT_CH3_ADDR = 8'h96; // Channel 3 options
  localparam logic [7:0] TEST_ADDR = 8'h97; // Test/control register
  // Reset values
  localparam logic [7:0] OPT_RESET = 8'h0C; // Snap on, guard 32
  localparam logic [7:0] TEST_RESET = 8'hF1; // Glitch, rollover, scale set
  localparam logic [7:0] OPT_USED_MASK = 8'h3F; // Reserved bits read zero
  // Option field positions
  localparam int OPT_UPDT_LO = 0;
  localparam int OPT_SNAP = 2;
  localparam int OPT_GRD_LO = 3;
  localparam int OPT_OPP = 5;
  // Test register field positions
  localparam int TEST_GLITCH = 0;
  localparam int TEST_SYNC_BASE = 1;
  localparam int TEST_TACH_ROLLOVER_SELECT = 4;
  localparam int TEST_SCALE_BASE = 5;
  // Clocks
  localparam int CLOCK_HZ = 25_000_000;
  localparam int OSC_HZ = 90_000;
  localparam int OSC_DIV_CYCLES = CLOCK_HZ / OSC_HZ; // Clocks per oscillator tick
  // Update periods in ms and in oscillator ticks
  localparam int UPD_SLOW_MS = 1000;
  localparam int UPD_MID_MS = 500;
  localparam int UPD_FAST_MS = 300;
  localparam int UPD_SLOW_TICKS = UPD_SLOW_MS * (OSC_HZ / 1000);
  localparam int UPD_MID_TICKS = UPD_MID_MS * (OSC_HZ / 1000);
  localparam int UPD_FAST_TICKS = UPD_FAST_MS * (OSC_HZ / 1000);
  // Guard times in oscillator clocks
  localparam logic [5:0] GUARD_00 = 6'd63;
  localparam logic [5:0] GUARD_01 = 6'd32;
  localparam logic [5:0] GUARD_10 = 6'd16;
  localparam logic [5:0] GUARD_11 = 6'd8;
  // Tach rollover values
  localparam logic [15:0] ROLL_SMALL = 16'h0080;
  localparam logic [15:0] ROLL_LARGE = 16'hFFFF;
  // Spin-up states
  typedef enum logic [2:0] {
    SPIN_RUN = 3'b001,
    SPIN_ACTIVE = 3'b010,
    SPIN_WAIT = 3'b100
  } spin_e;
endpackage

// File: fan_pwm_tach_options.sv
// Three-channel fan PWM driver with tach measurement and option registers
`timescale 1ns/100ps
module fan_pwm_tach_options #(
  parameter int UPD_SLOW_TICKS = fan_pwm_opt_pkg::UPD_SLOW_TICKS,
  parameter int UPD_MID_TICKS = fan_pwm_opt_pkg::UPD_MID_TICKS,
  parameter int UPD_FAST_TICKS = fan_pwm_opt_pkg::UPD_FAST_TICKS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic configLock,
  // Per-channel controls
  input wire logic [7:0] dutyCh1,
  input wire logic [7:0] dutyCh2,
  input wire logic [7:0] dutyCh3,
  input wire logic [2:0] pwmTick,
  input wire logic [2:0] rampTick,
  input wire logic [2:0] spinupReq,
  input wire logic [2:0] tachMode2,
  // Fan pins
  input wire logic [2:0] tachIn,
  output logic [2:0] pwmOut,
  // Tach readings
  output logic [15:0] tachReadingCh1,
  output logic [15:0] tachReadingCh2,
  output logic [15:0] tachReadingCh3
);
  // Address of a channel's option register
  function automatic logic [7:0] optAddr(input int ch);
    case (ch)
      0: optAddr = fan_pwm_opt_pkg::OPT_CH1_ADDR;
      1: optAddr = fan_pwm_opt_pkg::OPT_CH2_ADDR;
      default: optAddr = fan_pwm_opt_pkg::OPT_CH3_ADDR;
    endcase
  endfunction

  logic [7:0] test_q; // Shared test/control register
  logic [7:0] opt_q [3]; // Per-channel option registers
  logic [15:0] reading_q [3]; // Published tach readings
  logic [7:0] regRdata_q; // Registered read data
  logic [8:0] oscCnt_q; // Oscillator divider
  logic oscTick; // One-cycle 90 kHz tick
  logic [7:0] dutyIn [3];
  wire testWr = regWrite && (regAddr == fan_pwm_opt_pkg::TEST_ADDR);
  wire glitchSel = test_q[fan_pwm_opt_pkg::TEST_GLITCH];
  wire [15:0] rollVal = test_q[fan_pwm_opt_pkg::TEST_TACH_ROLLOVER_SELECT] ?
      fan_pwm_opt_pkg::ROLL_LARGE : fan_pwm_opt_pkg::ROLL_SMALL;

  assign dutyIn[0] = dutyCh1;
  assign dutyIn[1] = dutyCh2;
  assign dutyIn[2] = dutyCh3;
  assign oscTick = (oscCnt_q == 9'(fan_pwm_opt_pkg::OSC_DIV_CYCLES - 1));
  assign tachReadingCh1 = reading_q[0];
  assign tachReadingCh2 = reading_q[1];
  assign tachReadingCh3 = reading_q[2];
  assign regRdata = regRdata_q;

  // Oscillator divider: tach logic is timed by this tick
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      oscCnt_q <= 9'h000;
    end else begin
      oscCnt_q <= oscTick ? 9'h000 : oscCnt_q + 9'h001;
    end
  end

  // Test register is never locked
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      test_q <= fan_pwm_opt_pkg::TEST_RESET;
    end else if (testWr) begin
      test_q <= regWdata;
    end
  end

  // Read mux
  wire [7:0] rdMux =
      (regAddr == fan_pwm_opt_pkg::OPT_CH1_ADDR) ? opt_q[0] :
      (regAddr == fan_pwm_opt_pkg::OPT_CH2_ADDR) ? opt_q[1] :
      (regAddr == fan_pwm_opt_pkg::OPT_CH3_ADDR) ? opt_q[2] :
      (regAddr == fan_pwm_opt_pkg::TEST_ADDR) ? test_q : 8'h00;

  // Read data follows the address one cycle later
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdata_q <= 8'h00;
    end else begin
      regRdata_q <= rdMux;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : gChan
    // Option fields
    wire optWr = regWrite && (regAddr == optAddr(i)) && !configLock;
    wire [1:0] updSel = opt_q[i][fan_pwm_opt_pkg::OPT_UPDT_LO +: 2];
    wire snapEn = opt_q[i][fan_pwm_opt_pkg::OPT_SNAP];
    wire [1:0] grdSel = opt_q[i][fan_pwm_opt_pkg::OPT_GRD_LO +: 2];
    wire oppEn = opt_q[i][fan_pwm_opt_pkg::OPT_OPP];
    wire syncExit = test_q[fan_pwm_opt_pkg::TEST_SYNC_BASE + i];
    wire scale256 = test_q[fan_pwm_opt_pkg::TEST_SCALE_BASE + i];
    logic [7:0] cur_q; // Ramped duty actually driven
    logic [7:0] cnt_q; // PWM period counter
    logic pwm_q; // Registered PWM level
    fan_pwm_opt_pkg::spin_e spin_q; // Spin-up state
    logic [5:0] guard_q; // Guard countdown
    logic s1_q, s2_q, s3_q, clean_q; // Tach sampling chain
    logic [15:0] per_q; // Tach period counter
    logic haveEdge_q; // A first edge has been seen
    logic [15:0] pend_q; // Latest valid measurement
    logic pendValid_q; // Pending measurement present
    logic [16:0] upd_q; // Update timer

    // Option register write, blocked by lock
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        opt_q[i] <= fan_pwm_opt_pkg::OPT_RESET;
      end else if (optWr) begin
        opt_q[i] <= regWdata & fan_pwm_opt_pkg::OPT_USED_MASK;
      end
    end

    // Period wrap: 256 or 64 counts
    wire wrap = scale256 ? (cnt_q == 8'hFF) : (cnt_q[5:0] == 6'h3F);
    wire periodStart = pwmTick[i] && wrap;
    wire cmpHigh = scale256 ? (cnt_q < cur_q) :
        ({2'b00, cnt_q[5:0]} < {2'b00, cur_q[7:2]});
    wire spinning = (spin_q != fan_pwm_opt_pkg::SPIN_RUN);
    wire pwmNext = spinning || cmpHigh;
    wire pwmRise = pwmNext && !pwm_q;

    // PWM counter and output
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        cnt_q <= 8'h00;
        pwm_q <= 1'b0;
      end else begin
        pwm_q <= pwmNext;
        if (pwmTick[i]) begin
          cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
        end
      end
    end

    // Duty ramp with optional snap to zero
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        cur_q <= 8'h00;
      end else if (dutyIn[i] == 8'h00 && snapEn) begin
        cur_q <= 8'h00;
      end else if (rampTick[i] && cur_q > dutyIn[i]) begin
        cur_q <= cur_q - 8'h01;
      end else if (rampTick[i] && cur_q < dutyIn[i]) begin
        cur_q <= cur_q + 8'h01;
      end
    end

    // Spin-up exit, immediate or at next period start
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        spin_q <= fan_pwm_opt_pkg::SPIN_RUN;
      end else begin
        unique case (spin_q)
          fan_pwm_opt_pkg::SPIN_RUN: begin
            if (spinupReq[i]) spin_q <= fan_pwm_opt_pkg::SPIN_ACTIVE;
          end
          fan_pwm_opt_pkg::SPIN_ACTIVE: begin
            if (!spinupReq[i] && !syncExit) begin
              spin_q <= fan_pwm_opt_pkg::SPIN_RUN;
            end else if (!spinupReq[i]) begin
              spin_q <= fan_pwm_opt_pkg::SPIN_WAIT;
            end
          end
          fan_pwm_opt_pkg::SPIN_WAIT: begin
            if (spinupReq[i]) spin_q <= fan_pwm_opt_pkg::SPIN_ACTIVE;
            else if (periodStart) spin_q <= fan_pwm_opt_pkg::SPIN_RUN;
          end
          default: spin_q <= fan_pwm_opt_pkg::SPIN_RUN;
        endcase
      end
    end

    // Guard length from selector
    wire [5:0] guardLen = (grdSel == 2'b00) ? fan_pwm_opt_pkg::GUARD_00 :
        (grdSel == 2'b01) ? fan_pwm_opt_pkg::GUARD_01 :
        (grdSel == 2'b10) ? fan_pwm_opt_pkg::GUARD_10 : fan_pwm_opt_pkg::GUARD_11;

    // Guard countdown restarts on each PWM rise
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        guard_q <= 6'h00;
      end else if (pwmRise) begin
        guard_q <= guardLen;
      end else if (oscTick && guard_q != 6'h00) begin
        guard_q <= guard_q - 6'h01;
      end
    end

    // Tach conditioning on the oscillator tick
    wire cleanNext = glitchSel ? ((s2_q == s3_q) ? s3_q : clean_q) : s3_q;
    wire tachRise = oscTick && cleanNext && !clean_q;
    wire measureOk = !tachMode2[i] || (pwm_q && guard_q == 6'h00);
    wire gotValid = tachRise && haveEdge_q && measureOk;

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        // Idle high like the pulled-up pin, so reset makes no false rise
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        s3_q <= 1'b1;
        clean_q <= 1'b1;
      end else if (oscTick) begin
        s1_q <= tachIn[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        clean_q <= cleanNext;
      end
    end

    // Period measurement between tach rises
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        per_q <= 16'h0000;
        haveEdge_q <= 1'b0;
      end else if (oscTick && !measureOk) begin
        per_q <= 16'h0000;
        haveEdge_q <= 1'b0;
      end else if (tachRise) begin
        per_q <= 16'h0000;
        haveEdge_q <= 1'b1;
      end else if (oscTick && per_q < rollVal) begin
        per_q <= per_q + 16'h0001;
      end
    end

    // Update period selection
    wire [16:0] updLimit = (updSel == 2'b00) ? 17'(UPD_SLOW_TICKS - 1) :
        (updSel == 2'b01) ? 17'(UPD_MID_TICKS - 1) : 17'(UPD_FAST_TICKS - 1);
    wire updDue = oscTick && (upd_q >= updLimit);
    wire oppHit = oppEn && gotValid;

    // Update timer and reading publish
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        upd_q <= 17'h00000;
        pend_q <= 16'h0000;
        pendValid_q <= 1'b0;
        reading_q[i] <= 16'h0000;
      end else begin
        if (oppHit) begin
          upd_q <= 17'h00000;
          reading_q[i] <= per_q;
          pendValid_q <= 1'b0;
        end else if (updDue) begin
          upd_q <= 17'h00000;
          // A reading landing on the update edge is kept, not lost
          pendValid_q <= gotValid;
          if (gotValid) pend_q <= per_q;
          if (pendValid_q) reading_q[i] <= pend_q;
          else if (per_q == rollVal) reading_q[i] <= rollVal;
        end else begin
          if (oscTick) upd_q <= upd_q + 17'h00001;
          if (gotValid) begin
            pend_q <= per_q;
            pendValid_q <= 1'b1;
          end
        end
      end
    end

    assign pwmOut[i] = pwm_q;
  end
endmodule

// File: fan_pwm_tach_options_sva.sv
// Assertions on the register port and PWM outputs of the fan option block
`timescale 1ns/100ps
module fan_pwm_tach_options_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic configLock,
  // PWM side
  input wire logic [7:0] dutyCh1,
  input wire logic [2:0] pwmTick,
  input wire logic [2:0] rampTick,
  input wire logic [2:0] spinupReq,
  input wire logic [2:0] pwmOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Any option register addressed
  wire optSel = regAddr inside {8'h94, 8'h95, 8'h96};
  chk_lock_hold:
    assert property ((configLock && regAddr == 8'h94)[*4] |-> $stable(regRdata))
    else $error("locked option register changed");
  chk_write_read:
    assert property ((regWrite && !configLock && regAddr == 8'h94) ##1
      (regAddr == 8'h94 && !regWrite) |=> regRdata == ($past(regWdata, 2) & 8'h3F))
    else $error("option write not read back");
  chk_test_rw:
    assert property ((regWrite && regAddr == 8'h97) ##1 (regAddr == 8'h97 && !regWrite)
      |=> regRdata == $past(regWdata, 2))
    else $error("test register write not read back");
  chk_resv_zero:
    assert property (optSel |=> regRdata[7:6] == 2'b00)
    else $error("reserved option bits not zero");
  chk_unmapped_zero:
    assert property (!(optSel || regAddr == 8'h97) |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_spin_ch1:
    assert property (spinupReq[0] ##1 spinupReq[0] |=> pwmOut[0])
    else $error("channel 1 not high in spin-up");
  chk_spin_ch2:
    assert property (spinupReq[1][*2] |=> pwmOut[1])
    else $error("channel 2 not high in spin-up");
  chk_pwm_quiet:
    assert property ((!pwmTick[0] && !rampTick[0] && !regWrite && !spinupReq[0]
      && $stable(dutyCh1))[*4] |-> $stable(pwmOut[0]))
    else $error("PWM changed without cause");
endmodule

// File: fan_tach_model.sv
// Fan model: free-running tach output of a spinning fan
`timescale 1ns/100ps
module fan_tach_model #(
  parameter int HALF = 2770 // Clocks per tach half period
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Tach pin
  output logic tachOut
);
  int cnt; // Clocks into current half period
  // Toggle the tach line each half period
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      tachOut <= 1'b1; // Pulled-up idle level
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      tachOut <= ~tachOut;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: fan_pwm_tach_options_test.sv
// Self-checking bench for the fan PWM and tach option block
`timescale 1ns/100ps
module fan_pwm_tach_options_test;
  logic clock = 0, resetn = 0, regWrite = 0, configLock = 0; // Clock, reset, bus
  logic [7:0] regAddr = 0, regWdata = 0, regRdata, d1 = 0, d2 = 0; // Bus, duties
  logic [2:0] pwmTick = 0, rampTick = 0, spinupReq = 0, pwmOut; // PWM controls
  logic [15:0] r1, r2, r3; // Tach readings
  logic fanA, fanB; // Fan tach lines
  logic tach3 = 1'b1; // Third tach line, held high
  logic [7:0] d3 = 8'h00; // Channel 3 duty
  logic [2:0] mode2 = 3'b100; // Tach mode 2 per channel
  logic [31:0] rng = 32'hEA7714BF; // Xorshift state
  logic [7:0] regs [int]; // Register model
  int n_fail = 0, n_tests = 0, hi;
  always #20 clock = ~clock;
  fan_tach_model #(.HALF(2770)) fa (.clock(clock), .resetn(resetn), .tachOut(fanA));
  fan_tach_model #(.HALF(2770)) fb (.clock(clock), .resetn(resetn), .tachOut(fanB));
  fan_pwm_tach_options #(.UPD_SLOW_TICKS(40), .UPD_MID_TICKS(20), .UPD_FAST_TICKS(12)) dut (
    .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .configLock(configLock),
    .dutyCh1(d1), .dutyCh2(d2), .dutyCh3(d3), .pwmTick(pwmTick), .rampTick(rampTick),
    .spinupReq(spinupReq), .tachMode2(mode2), .tachIn({tach3, fanB, fanA}),
    .pwmOut(pwmOut), .tachReadingCh1(r1), .tachReadingCh2(r2), .tachReadingCh3(r3));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  // One register write, mirrored in the model
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    if (!configLock || a == 8'h97) regs[a] = (a == 8'h97) ? d : (d & 8'h3F);
  endtask
  // One register read against the model
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regAddr <= a;
    @(posedge clock);
    @(negedge clock);
    check({8'h00, regRdata}, {8'h00, regs.exists(a) ? regs[a] : 8'h00});
  endtask
  // High cycles of one PWM output
  task automatic count(input int ch, input int n);
    hi = 0;
    repeat (n) begin
      @(negedge clock);
      hi += pwmOut[ch];
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    regs[8'h94] = 8'h0C;
    regs[8'h95] = 8'h0C;
    regs[8'h96] = 8'h0C;
    regs[8'h97] = 8'hF1;
    for (int a = 8'h93; a <= 8'h98; a++) rd(a[7:0]);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) begin
        @(posedge clock);
        configLock <= 1'b1;
      end
      wr(8'h94 + i[7:0] % 4, rnd());
      rd(8'h94 + i[7:0] % 4);
    end
    $display("register test done");
    @(posedge clock);
    configLock <= 1'b0;
    wr(8'h94, 8'h28);
    wr(8'h95, 8'h0E);
    wr(8'h96, 8'h0E);
    wr(8'h97, 8'h23);
    d1 <= 8'h43;
    d2 <= 8'h43;
    pwmTick <= 3'b111;
    rampTick <= 3'b111;
    repeat (300) @(posedge clock);
    count(0, 256);
    check(hi[15:0], 16'd67);
    count(1, 256);
    check(hi[15:0], 16'd64);
    @(posedge clock);
    rampTick <= 3'b000;
    d1 <= 8'h00;
    d2 <= 8'h00;
    repeat (3) @(posedge clock);
    count(1, 256);
    check(hi[15:0], 16'd0);
    count(0, 256);
    check(hi[15:0], 16'd67);
    @(posedge clock);
    rampTick <= 3'b111;
    repeat (300) @(posedge clock);
    count(0, 256);
    check(hi[15:0], 16'd0);
    $display("duty test done");
    @(posedge clock);
    pwmTick <= 3'b000;
    rampTick <= 3'b000;
    spinupReq <= 3'b011;
    repeat (5) @(posedge clock);
    spinupReq <= 3'b000;
    repeat (20) @(negedge clock);
    check({14'h0, pwmOut[1:0]}, 16'h0001);
    @(posedge clock);
    pwmTick <= 3'b111;
    repeat (260) @(negedge clock);
    check({14'h0, pwmOut[1:0]}, 16'h0000);
    $display("spin-up test done");
    repeat (40000) @(posedge clock);
    @(negedge clock);
    check({15'h0, r1 >= 16'd19 && r1 <= 16'd21}, 16'h0001);
    check({15'h0, r2 >= 16'd19 && r2 <= 16'd21}, 16'h0001);
    check(r3, 16'h0000);
    $display("tach test done");
    @(posedge clock);
    mode2 <= 3'b000;
    repeat (40000) @(posedge clock);
    @(negedge clock);
    check(r3, 16'h0080);
    $display("rollover test done");
    conclude();
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge clock);
    n_fail++;
    conclude();
  end
endmodule
bind fan_pwm_tach_options fan_pwm_tach_options_sva chk (.clock(clock), .resetn(resetn),
  .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
  .configLock(configLock), .dutyCh1(dutyCh1), .pwmTick(pwmTick), .rampTick(rampTick),
  .spinupReq(spinupReq), .pwmOut(pwmOut));
